// ### shared/swm_pkg.sv
// Constants, timing counts and types of the single-wire bus master
package swm_pkg;

  localparam int CLK_NS = 4;
  localparam int TMR_W  = 18;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_dn

  // Times in ns
  localparam int RST_FALL_NS     = 0;
  localparam int RST_LOW_STD_NS  = 690000;
  localparam int RST_LOW_OD_NS   = 70000;
  localparam int RST_HIGH_STD_NS = 480000;
  localparam int RST_HIGH_OD_NS  = 48000;
  localparam int PRES_STD_NS     = 70000;
  localparam int PRES_OD_NS      = 8500;
  localparam int W1L_STD_NS      = 6000;
  localparam int W1L_OD_NS       = 1000;
  localparam int W0L_STD_NS      = 60000;
  localparam int W0L_OD_NS       = 7500;
  localparam int RL_STD_NS       = 6000;
  localparam int RL_OD_NS        = 1000;
  localparam int MSR_STD_NS      = 13000;
  localparam int MSR_OD_NS       = 1750;
  localparam int REC_STD_NS      = 10000;
  localparam int REC_OD_NS       = 3000;

  // Cycle counts; least times round up, latest times round down
  localparam logic [TMR_W-1:0] RST_LOW_STD_CYC  =
    TMR_W'(cyc_up(RST_LOW_STD_NS + RST_FALL_NS));
  localparam logic [TMR_W-1:0] RST_LOW_OD_CYC   =
    TMR_W'(cyc_up(RST_LOW_OD_NS + RST_FALL_NS));
  localparam logic [TMR_W-1:0] RST_HIGH_STD_CYC = TMR_W'(cyc_up(RST_HIGH_STD_NS));
  localparam logic [TMR_W-1:0] RST_HIGH_OD_CYC  = TMR_W'(cyc_up(RST_HIGH_OD_NS));
  localparam logic [TMR_W-1:0] PRES_STD_CYC     = TMR_W'(cyc_up(PRES_STD_NS));
  localparam logic [TMR_W-1:0] PRES_OD_CYC      = TMR_W'(cyc_up(PRES_OD_NS));
  localparam logic [TMR_W-1:0] W1L_STD_CYC      = TMR_W'(cyc_dn(W1L_STD_NS));
  localparam logic [TMR_W-1:0] W1L_OD_CYC       = TMR_W'(cyc_dn(W1L_OD_NS));
  localparam logic [TMR_W-1:0] W0L_STD_CYC      = TMR_W'(cyc_up(W0L_STD_NS));
  localparam logic [TMR_W-1:0] W0L_OD_CYC       = TMR_W'(cyc_up(W0L_OD_NS));
  localparam logic [TMR_W-1:0] RL_STD_CYC       = TMR_W'(cyc_dn(RL_STD_NS));
  localparam logic [TMR_W-1:0] RL_OD_CYC        = TMR_W'(cyc_dn(RL_OD_NS));
  localparam logic [TMR_W-1:0] MSR_STD_CYC      = TMR_W'(cyc_dn(MSR_STD_NS));
  localparam logic [TMR_W-1:0] MSR_OD_CYC       = TMR_W'(cyc_dn(MSR_OD_NS));
  localparam logic [TMR_W-1:0] REC_STD_CYC      = TMR_W'(cyc_up(REC_STD_NS));
  localparam logic [TMR_W-1:0] REC_OD_CYC       = TMR_W'(cyc_up(REC_OD_NS));

  // User commands
  localparam int             OP_W         = 2;
  localparam logic [OP_W-1:0] OP_RESET     = 2'h0;
  localparam logic [OP_W-1:0] OP_RESET_STD = 2'h1;
  localparam logic [OP_W-1:0] OP_WRITE     = 2'h2;
  localparam logic [OP_W-1:0] OP_READ      = 2'h3;

  // ROM command bytes; the master watches the overdrive skip and match ones
  localparam logic [7:0] ROM_OD_SKIP  = 8'h3c;
  localparam logic [7:0] ROM_OD_MATCH = 8'h69;
  localparam logic [7:0] ROM_RESUME   = 8'ha5;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RST_LOW,
    ST_RST_HIGH,
    ST_SLOT,
    ST_PUSH
  } swm_state_e;

endpackage : swm_pkg

// ### design/swm_fifo.sv
// Receive FIFO between the slot engine and the user
`timescale 1ns/1ps
`default_nettype none
module swm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             in_ready_reg;
  logic             out_valid_reg;
  logic             push;
  logic             pop;
  logic [WIDTH-1:0] out_data_reg;
  logic [AW-1:0]    rd_ptr_next;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  assign push       = in_valid && in_ready_reg;
  assign pop        = out_valid_reg && out_ready;
  assign count_next = count_reg + CW'(push) - CW'(pop);
  assign in_ready   = in_ready_reg;
  assign out_valid  = out_valid_reg;
  assign rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
  assign out_data   = out_data_reg;

  // Head is a flop for the user; a push into an emptying FIFO bypasses storage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      out_data_reg <= '0;
    else if (push && (count_reg == CW'(pop)))
      out_data_reg <= in_data;
    else
      out_data_reg <= mem_reg[rd_ptr_next];
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
    end
  end

  // Flags are registered from the next count so they never lag a transfer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg     <= '0;
      in_ready_reg  <= 1'b1;
      out_valid_reg <= 1'b0;
    end
    else
    begin
      count_reg     <= count_next;
      in_ready_reg  <= (count_next != CW'(DEPTH));
      out_valid_reg <= (count_next != '0);
    end
  end

  AST_FIFO_FULL_STALLS: assert property (@(posedge clk) disable iff (!rst_n)
    (count_reg == CW'(DEPTH)) |-> !in_ready_reg && out_valid_reg)
    else $error("FIFO full but still ready");

endmodule : swm_fifo
`default_nettype wire

// ### design/swm_master.sv
// Single-wire bus master: reset/presence, byte slots, speed tracking
// Contract
// - Reset of 690us returns standard speed.
// - After overdrive skip, master switches to overdrive.
// - Command 69h then 64-bit code at overdrive.
// - Master samples presence at the sample point.
// - Reset-high window covers presence and recovery.
// - Reset-high window 480us standard, 48us overdrive.
// - Write-one releases before maximum low time.
// - Write-zero holds low for minimum time.
// - Recovery interval before next slot.
// - Short read low, sample before latest point.
// - Wait full slot before next slot.
// - Reset low extended by fall time.
`timescale 1ns/1ps
`default_nettype none
module swm_master #(
  parameter int unsigned               FIFO_DEPTH   = swm_pkg::FIFO_DEPTH,
  parameter logic [swm_pkg::TMR_W-1:0] RST_LOW_STD  = swm_pkg::RST_LOW_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] RST_LOW_OD   = swm_pkg::RST_LOW_OD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] RST_HIGH_STD = swm_pkg::RST_HIGH_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] RST_HIGH_OD  = swm_pkg::RST_HIGH_OD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] PRES_STD     = swm_pkg::PRES_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] PRES_OD      = swm_pkg::PRES_OD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] W1L_STD      = swm_pkg::W1L_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] W1L_OD       = swm_pkg::W1L_OD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] W0L_STD      = swm_pkg::W0L_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] W0L_OD       = swm_pkg::W0L_OD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] RL_STD       = swm_pkg::RL_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] RL_OD        = swm_pkg::RL_OD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] MSR_STD      = swm_pkg::MSR_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] MSR_OD       = swm_pkg::MSR_OD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] REC_STD      = swm_pkg::REC_STD_CYC,
  parameter logic [swm_pkg::TMR_W-1:0] REC_OD       = swm_pkg::REC_OD_CYC
) (
  input  wire logic                    CLK,
  input  wire logic                    RST_N,
  input  wire logic                    CMD_VALID,
  output logic                         CMD_READY,
  input  wire logic [swm_pkg::OP_W-1:0] CMD_OP,
  input  wire logic [7:0]              CMD_DATA,
  output logic                         RX_VALID,
  input  wire logic                    RX_READY,
  output logic      [7:0]              RX_DATA,
  output logic                         PRESENCE,
  output logic                         OVERDRIVE,
  input  wire logic                    DQ_IN,
  output logic                         DQ_OUT,
  output logic                         DQ_OE
);
  import swm_pkg::*;

  swm_state_e       state_reg;
  swm_state_e       state_next;
  logic [TMR_W-1:0] timer_reg;
  logic [TMR_W-1:0] timer_next;
  logic [TMR_W-1:0] rst_low_cnt;
  logic [TMR_W-1:0] rst_high_cnt;
  logic [TMR_W-1:0] pres_cnt;
  logic [TMR_W-1:0] low_cnt;
  logic [TMR_W-1:0] samp_cnt;
  logic [TMR_W-1:0] slot_cnt;
  logic [2:0]       bit_idx_reg;
  logic [7:0]       shift_reg;
  logic [7:0]       cmd_byte_reg;
  logic             read_reg;
  logic             samp_bit_reg;
  logic             od_reg;
  logic             presence_reg;
  logic             rom_phase_reg;
  logic             cmd_ready_reg;
  logic             dq_oe_reg;
  logic             dq_out_reg;
  logic             dq_meta_reg;
  logic             dq_sync_reg;
  logic             cmd_take;
  logic             slot_end;
  logic             byte_done;
  logic             push_valid;
  logic             push_ready;

  function automatic logic [TMR_W-1:0] pick(
    input logic             fast,
    input logic [TMR_W-1:0] std_v,
    input logic [TMR_W-1:0] od_v
  );
    return fast ? od_v : std_v;
  endfunction : pick

  // Every waveform follows the current speed
  always_comb
  begin
    rst_low_cnt  = pick(od_reg, RST_LOW_STD, RST_LOW_OD);
    rst_high_cnt = pick(od_reg, RST_HIGH_STD, RST_HIGH_OD);
    pres_cnt     = pick(od_reg, PRES_STD, PRES_OD);
    samp_cnt     = pick(od_reg, MSR_STD, MSR_OD);
    // Slot length = longest low time plus recovery
    slot_cnt     = pick(od_reg, W0L_STD + REC_STD, W0L_OD + REC_OD);
    if (read_reg)
      low_cnt = pick(od_reg, RL_STD, RL_OD);
    else if (shift_reg[0])
      low_cnt = pick(od_reg, W1L_STD, W1L_OD);
    else
      low_cnt = pick(od_reg, W0L_STD, W0L_OD);
  end

  assign cmd_take  = CMD_VALID && cmd_ready_reg;
  assign slot_end  = (state_reg == ST_SLOT) && (timer_reg == slot_cnt - 1'b1);
  assign byte_done = slot_end && (bit_idx_reg == 3'h7);

  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg + 1'b1;
    unique case (state_reg)
      ST_IDLE:
      begin
        timer_next = '0;
        if (cmd_take)
          state_next = (CMD_OP == OP_RESET || CMD_OP == OP_RESET_STD) ? ST_RST_LOW : ST_SLOT;
      end
      ST_RST_LOW:
      begin
        if (timer_reg == rst_low_cnt - 1'b1)
        begin
          state_next = ST_RST_HIGH;
          timer_next = '0;
        end
      end
      ST_RST_HIGH:
      begin
        if (timer_reg == rst_high_cnt - 1'b1)
        begin
          state_next = ST_IDLE;
          timer_next = '0;
        end
      end
      ST_SLOT:
      begin
        if (slot_end)
        begin
          timer_next = '0;
          if (bit_idx_reg == 3'h7)
            state_next = read_reg ? ST_PUSH : ST_IDLE;
        end
      end
      ST_PUSH:
      begin
        timer_next = '0;
        if (push_ready)
          state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_reg     <= ST_IDLE;
      timer_reg     <= '0;
      cmd_ready_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      timer_reg     <= timer_next;
      cmd_ready_reg <= (state_next == ST_IDLE);
    end
  end

  // Line drive lags the state by one cycle; durations stay exact
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      dq_oe_reg  <= 1'b0;
      dq_out_reg <= 1'b0;
    end
    else
    begin
      dq_oe_reg  <= (state_reg == ST_RST_LOW)
                    || (state_reg == ST_SLOT && timer_reg < low_cnt);
      dq_out_reg <= 1'b0;
    end
  end

  // The line is asynchronous to CLK
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      dq_meta_reg <= 1'b1;
      dq_sync_reg <= 1'b1;
    end
    else
    begin
      dq_meta_reg <= DQ_IN;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      samp_bit_reg <= 1'b1;
    else if (state_reg == ST_SLOT && read_reg && timer_reg == samp_cnt)
      samp_bit_reg <= dq_sync_reg;
  end

  // Bits leave and arrive least significant first
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      shift_reg    <= '0;
      cmd_byte_reg <= '0;
      bit_idx_reg  <= '0;
      read_reg     <= 1'b0;
    end
    else if (cmd_take)
    begin
      shift_reg    <= CMD_DATA;
      cmd_byte_reg <= CMD_DATA;
      bit_idx_reg  <= '0;
      read_reg     <= (CMD_OP == OP_READ);
    end
    else if (slot_end)
    begin
      shift_reg   <= {read_reg ? samp_bit_reg : 1'b0, shift_reg[7:1]};
      bit_idx_reg <= bit_idx_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      presence_reg <= 1'b0;
    else if (cmd_take && (CMD_OP == OP_RESET || CMD_OP == OP_RESET_STD))
      presence_reg <= 1'b0;
    else if (state_reg == ST_RST_HIGH && timer_reg == pres_cnt)
      presence_reg <= !dq_sync_reg;
  end

  // The first byte after a reset with presence is a ROM command
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      rom_phase_reg <= 1'b0;
    else if (state_reg == ST_RST_HIGH && state_next == ST_IDLE)
      rom_phase_reg <= presence_reg;
    // A write keeps the flag until its byte is out; reads and resets drop it
    else if (byte_done || (cmd_take && CMD_OP != OP_WRITE))
      rom_phase_reg <= 1'b0;
  end

  // A plain reset keeps the speed; only the long reset leaves overdrive
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      od_reg <= 1'b0;
    else if (cmd_take && CMD_OP == OP_RESET_STD)
      od_reg <= 1'b0;
    else if (byte_done && !read_reg && rom_phase_reg
             && (cmd_byte_reg == ROM_OD_SKIP || cmd_byte_reg == ROM_OD_MATCH))
      od_reg <= 1'b1;
  end

  assign push_valid = (state_reg == ST_PUSH);

  // A full FIFO holds the engine in ST_PUSH, so no byte is lost
  swm_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (shift_reg),
    .out_valid (RX_VALID),
    .out_ready (RX_READY),
    .out_data  (RX_DATA)
  );

  assign CMD_READY = cmd_ready_reg;
  assign PRESENCE  = presence_reg;
  assign OVERDRIVE = od_reg;
  assign DQ_OE     = dq_oe_reg;
  assign DQ_OUT    = dq_out_reg;

  // Checking helpers: run lengths of driven and released line
  logic [TMR_W-1:0] oe_len_reg;
  logic [TMR_W-1:0] gap_len_reg;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      oe_len_reg  <= '0;
      gap_len_reg <= '0;
    end
    else
    begin
      oe_len_reg  <= dq_oe_reg ? oe_len_reg + 1'b1 : '0;
      gap_len_reg <= dq_oe_reg ? '0 : (gap_len_reg == '1 ? gap_len_reg : gap_len_reg + 1'b1);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_STD_RESET_LOW: assert property (
    $fell(dq_oe_reg) && state_reg == ST_RST_HIGH && !od_reg |-> oe_len_reg == RST_LOW_STD)
    else $error("Standard reset low length wrong");

  AST_OD_RESET_LOW: assert property (
    $fell(dq_oe_reg) && state_reg == ST_RST_HIGH && od_reg |-> oe_len_reg == RST_LOW_OD)
    else $error("Overdrive reset low length wrong");

  AST_RESET_HIGH: assert property (
    $rose(cmd_ready_reg) && $past(state_reg) == ST_RST_HIGH
    |-> gap_len_reg == pick(od_reg, RST_HIGH_STD, RST_HIGH_OD) - 1'b1)
    else $error("Reset high window length wrong");

  AST_OD_ENTRY: assert property (
    byte_done && !read_reg && rom_phase_reg
    && (cmd_byte_reg == ROM_OD_SKIP || cmd_byte_reg == ROM_OD_MATCH)
    |=> od_reg && $past(state_next) == ST_IDLE)
    else $error("Overdrive not entered after select");

  AST_STD_LEAVE: assert property (
    cmd_take && CMD_OP == OP_RESET_STD |=> !od_reg ##1 dq_oe_reg)
    else $error("Long reset did not return to standard");

  AST_PRESENCE_SAMPLE: assert property (
    state_reg == ST_RST_HIGH && timer_reg == pres_cnt |=> PRESENCE == !$past(dq_sync_reg))
    else $error("Presence not sampled at sample point");

  AST_W1_LOW: assert property (
    $fell(dq_oe_reg) && state_reg == ST_SLOT && !read_reg && shift_reg[0]
    |-> oe_len_reg == pick(od_reg, W1L_STD, W1L_OD))
    else $error("Write-one low time wrong");

  AST_W0_LOW: assert property (
    $fell(dq_oe_reg) && state_reg == ST_SLOT && !read_reg && !shift_reg[0]
    |-> oe_len_reg == pick(od_reg, W0L_STD, W0L_OD))
    else $error("Write-zero low time wrong");

  AST_READ_LOW: assert property (
    $fell(dq_oe_reg) && state_reg == ST_SLOT && read_reg
    |-> oe_len_reg == pick(od_reg, RL_STD, RL_OD) && timer_reg <= samp_cnt)
    else $error("Read low time or sample order wrong");

  AST_SLOT_RECOVERY: assert property (
    $rose(dq_oe_reg) && state_reg == ST_SLOT |-> gap_len_reg >= pick(od_reg, REC_STD, REC_OD))
    else $error("Slot started before recovery");

  COV_PRESENCE: cover property (state_reg == ST_RST_HIGH && state_next == ST_IDLE && presence_reg);
  COV_OD_ENTRY: cover property (!od_reg ##1 od_reg);
  COV_READ_PUSH: cover property (push_valid && push_ready);
  COV_FIFO_STALL: cover property (push_valid && !push_ready);

endmodule : swm_master
`default_nettype wire

// ### verification/swm_slave_model.sv
// Behavioural slave on the single-wire line: presence, ROM layer, reply bytes
`timescale 1ns/1ps
`default_nettype none
module swm_slave_model #(
  parameter logic [63:0] ROM_ID = 64'h5a5a_0f0f_3c3c_a1b2, // Arbitrary value
  parameter logic [7:0]  RPL    = 8'h96
) (
  input  wire logic clk,
  input  wire logic attached,
  input  wire logic line,
  output logic      pull
);
  import swm_pkg::*;
  // Cycle counts, standard then overdrive; reply hold outlasts the master's sample point
  localparam int SMP_S = 6, SMP_F = 3, HLD_S = 9, HLD_F = 5, PDH_S = 2, PDH_F = 1;
  localparam int PDL_S = 12, PDL_F = 6, RDT_S = 16, RDT_F = 10, RLONG = 36;
  logic        od_reg = 1'b0, rc_reg = 1'b0, mlow_reg = 1'b0, pres_reg = 1'b0;
  logic [1:0]  ph_reg = 2'h0;
  logic [7:0]  rb_reg = 8'h00;
  logic [6:0]  nb_reg = 7'h00;
  logic [63:0] sh_reg = 64'h0;
  int          cnt = 0, pcnt = 0;
  int          smp, hld, pdh, pdl, rdt;
  logic [7:0]  rply, cmd;
  logic        wbit;
  initial pull = 1'b0;
  assign smp = od_reg ? SMP_F : SMP_S;
  assign hld = od_reg ? HLD_F : HLD_S;
  assign pdh = od_reg ? PDH_F : PDH_S;
  assign pdl = od_reg ? PDL_F : PDL_S;
  assign rdt = od_reg ? RDT_F : RDT_S;
  assign rply = RPL + {3'h0, rb_reg[7:3]};
  // Line back high before the sample point means a one
  assign wbit = cnt < smp;
  assign cmd = {wbit, sh_reg[63:57]};
  always @(posedge clk)
  begin
    if (pres_reg)
    begin
      pull <= pcnt >= pdh && pcnt < pdh + pdl;
      pcnt <= pcnt + 1;
      if (pcnt == pdh + pdl)
        pres_reg <= 1'b0;
    end
    if (!mlow_reg && !line && !pull)
    begin
      mlow_reg <= 1'b1;
      cnt <= 1;
      if (ph_reg == 2'h3)
        pull <= !rply[rb_reg[2:0]];
    end
    else if (mlow_reg && line)
    begin
      mlow_reg <= 1'b0;
      if (cnt >= rdt)
      begin
        if (cnt >= RLONG)
          od_reg <= 1'b0;
        ph_reg <= attached ? 2'h1 : 2'h0;
        pres_reg <= attached;
        pcnt <= 1;
        nb_reg <= 7'h00;
        rb_reg <= 8'h00;
      end
      else if (ph_reg == 2'h3)
        rb_reg <= rb_reg + 8'h01;
      else if (ph_reg != 2'h0)
      begin
        sh_reg <= {wbit, sh_reg[63:1]};
        nb_reg <= nb_reg + 7'h01;
        if (ph_reg == 2'h1 && nb_reg == 7'h07)
        begin
          nb_reg <= 7'h00;
          case (cmd)
            ROM_OD_SKIP: {od_reg, ph_reg} <= 3'h7;
            ROM_OD_MATCH: {od_reg, ph_reg} <= 3'h6;
            8'h55: ph_reg <= 2'h2;
            ROM_RESUME: ph_reg <= rc_reg ? 2'h3 : 2'h0;
            default: ph_reg <= 2'h0;
          endcase
        end
        if (ph_reg == 2'h2 && nb_reg == 7'h3f)
          {rc_reg, ph_reg} <= ({wbit, sh_reg[63:1]} == ROM_ID) ? 3'h7 : 3'h0;
      end
    end
    else if (mlow_reg)
    begin
      cnt <= cnt + 1;
      if (cnt == hld)
        pull <= 1'b0;
    end
  end
endmodule : swm_slave_model
`default_nettype wire

// ### verification/swm_master_test.sv
// Self-checking bench for the single-wire bus master
`timescale 1ns/1ps
`default_nettype none
module swm_master_test;
  import swm_pkg::*;
  localparam logic [63:0] ID  = 64'h5a5a_0f0f_3c3c_a1b2; // Arbitrary value
  localparam logic [7:0]  RPL = 8'h96;
  logic             clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, rx_ready = 1'b0;
  logic             attached = 1'b1;
  logic [OP_W-1:0]  cmd_op = OP_RESET;
  logic [7:0]       cmd_data = 8'h00;
  logic             cmd_ready, rx_valid, presence, overdrive, dq_out, dq_oe, pull;
  logic [7:0]       rx_data;
  logic [TMR_W-1:0] run_len = '0, last_len = '0;
  int               err_total = 0, n_tests = 0, cyc = 0;
  wire logic        line;
  // Pulled-up open-drain wire
  assign line = !((dq_oe && !dq_out) || pull);
  always #2 clk = ~clk;
  swm_master #(
    .RST_LOW_STD(TMR_W'(40)), .RST_LOW_OD(TMR_W'(20)), .RST_HIGH_STD(TMR_W'(40)),
    .RST_HIGH_OD(TMR_W'(20)), .PRES_STD(TMR_W'(14)), .PRES_OD(TMR_W'(8)),
    .W1L_STD(TMR_W'(2)), .W1L_OD(TMR_W'(1)), .W0L_STD(TMR_W'(12)), .W0L_OD(TMR_W'(6)),
    .RL_STD(TMR_W'(2)), .RL_OD(TMR_W'(1)), .MSR_STD(TMR_W'(8)), .MSR_OD(TMR_W'(5)),
    .REC_STD(TMR_W'(4)), .REC_OD(TMR_W'(2)), .FIFO_DEPTH(8)
  ) dut (
    .CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
    .RX_DATA(rx_data), .PRESENCE(presence), .OVERDRIVE(overdrive), .DQ_IN(line),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe)
  );
  swm_slave_model #(.ROM_ID(ID), .RPL(RPL)) slave (
    .clk(clk), .attached(attached), .line(line), .pull(pull)
  );
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Length of the last low pulse the master drove
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (dq_oe === 1'b1)
      run_len <= run_len + TMR_W'(1);
    else if (run_len != '0)
    begin
      last_len <= run_len;
      run_len <= '0;
    end
    if (cyc == 30000)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end
  task automatic chk_val(input logic [TMR_W-1:0] got, input logic [TMR_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag
  // Hands one command over and waits for the engine to come back idle
  task automatic issue(input logic [OP_W-1:0] op, input logic [7:0] d, input logic done);
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 1500)
    begin
      @(negedge clk);
      i++;
    end
    cmd_op = op;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (2) @(negedge clk);
    i = 0;
    while (cmd_ready !== 1'b1 && i < 1500)
    begin
      @(negedge clk);
      i++;
    end
    chk_flag(cmd_ready, done);
  endtask : issue
  task automatic pop(input logic [7:0] exp);
    int i;
    i = 0;
    while (rx_valid !== 1'b1 && i < 100)
    begin
      @(negedge clk);
      i++;
    end
    chk_val(TMR_W'(rx_data), TMR_W'(exp));
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask : pop
  task automatic rd(input logic [7:0] exp);
    issue(OP_READ, 8'h00, 1'b1);
    pop(exp);
  endtask : rd
  task automatic open_rom(input logic [OP_W-1:0] op, input logic [7:0] rom_cmd);
    issue(op, 8'h00, 1'b1);
    chk_flag(presence, 1'b1);
    issue(OP_WRITE, rom_cmd, 1'b1);
  endtask : open_rom
  task automatic send_id(input logic [63:0] id);
    for (int k = 0; k < 8; k++)
      issue(OP_WRITE, id[8*k +: 8], 1'b1);
  endtask : send_id
  task automatic t_basic;
    attached = 1'b0;
    issue(OP_RESET_STD, 8'h00, 1'b1);
    chk_flag(presence, 1'b0);
    chk_val(last_len, TMR_W'(40));
    attached = 1'b1;
    open_rom(OP_RESET, 8'h80);
    chk_val(last_len, TMR_W'(2));
    issue(OP_WRITE, 8'h7f, 1'b1);
    chk_val(last_len, TMR_W'(12));
  endtask : t_basic
  task automatic t_match;
    open_rom(OP_RESET, 8'h55);
    send_id(ID);
    rd(RPL);
    rd(RPL + 8'h01);
    open_rom(OP_RESET, ROM_RESUME);
    rd(RPL);
    open_rom(OP_RESET, 8'h55);
    send_id(ID ^ 64'h1);
    rd(8'hff);
    open_rom(OP_RESET, ROM_RESUME);
    rd(8'hff);
  endtask : t_match
  task automatic t_odskip;
    open_rom(OP_RESET, ROM_OD_SKIP);
    chk_flag(overdrive, 1'b1);
    rd(RPL);
    issue(OP_RESET, 8'h00, 1'b1);
    chk_val(last_len, TMR_W'(20));
    chk_flag(presence, 1'b1);
    chk_flag(overdrive, 1'b1);
    issue(OP_WRITE, ROM_RESUME, 1'b1);
    chk_val(last_len, TMR_W'(1));
    rd(8'hff);
    issue(OP_RESET_STD, 8'h00, 1'b1);
    chk_val(last_len, TMR_W'(40));
    chk_flag(overdrive, 1'b0);
  endtask : t_odskip
  task automatic t_odmatch;
    open_rom(OP_RESET, ROM_OD_MATCH);
    chk_flag(overdrive, 1'b1);
    send_id(ID);
    rd(RPL);
    open_rom(OP_RESET, ROM_RESUME);
    rd(RPL);
  endtask : t_odmatch
  task automatic t_fifo;
    open_rom(OP_RESET, ROM_RESUME);
    for (int k = 0; k < 8; k++)
      issue(OP_READ, 8'h00, 1'b1);
    // Ninth byte has no room, so the engine must stall
    issue(OP_READ, 8'h00, 1'b0);
    chk_flag(rx_valid, 1'b1);
    for (int k = 0; k < 9; k++)
      pop(RPL + 8'(k));
    chk_flag(cmd_ready, 1'b1);
  endtask : t_fifo
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_basic();
    t_match();
    t_odskip();
    t_odmatch();
    t_fifo();
    conclude();
  end
endmodule : swm_master_test
`default_nettype wire
